// ==== hdl/dma_global_control_status.sv ====
// Global control and status logic of an eight-channel DMA controller with an Avalon-MM register slave.
//
// Summary of operation
// - Combined status: masked error or terminal count.
// - Masked terminal-count status in bits seven down.
// - Writing ones clears terminal-count requests.
// - Masked error status in bits seven down.
// - Writing ones clears error requests.
// - Raw terminal-count requests before masking readable.
// - Raw error requests before masking readable.
// - Enabled channels view, cleared on completion.
// - Software burst request, set by one.
// - Software single request, set by one.
// - Software last-burst request, set by one.
// - Software last-single request, set by one.
// - Request from peripheral input or software bit.
// - Global enable bit, reset zero, saves power.
// - Two endianness bits for both masters.
// - Per-source synchronizer enable, one bypasses.
// - Four sixteen-bit peripheral request groups.
// - Separate terminal-count and error interrupt outputs.
// - Channel disabled after last item completes.
`timescale 1ns/1ps
module dma_global_control_status
   import dma_global_pkg::*;
(
   input  wire logic          sys_clk_i,
   input  wire logic          rst_n_i,
   input  wire logic [7:0]    avs_address_i,
   input  wire logic          avs_read_i,
   input  wire logic          avs_write_i,
   input  wire logic [31:0]   avs_writedata_i,
   input  wire logic [3:0]    avs_byteenable_i,
   output logic      [31:0]   avs_readdata_o,
   output logic               avs_waitrequest_o,
   input  wire req_group_type peripheral_request_in_i,
   input  wire src_vec_type   xfer_done_i,
   input  wire src_vec_type   clear_resp_i,
   input  wire src_vec_type   tc_resp_i,
   output src_vec_type        request_clear_response_o,
   output src_vec_type        terminal_count_response_o,
   input  wire chan_vec_type  tc_event_i,
   input  wire chan_vec_type  error_event_i,
   input  wire chan_vec_type  tc_irq_mask_i,
   input  wire chan_vec_type  error_irq_mask_i,
   input  wire chan_vec_type  chan_enable_set_i,
   input  wire chan_vec_type  chan_disable_i,
   input  wire chan_vec_type  last_item_done_i,
   output req_group_type      engine_request_o,
   output logic               controller_enable_o,
   output logic               master_one_big_endian_o,
   output logic               master_two_big_endian_o,
   output logic               combined_irq_out_o,
   output logic               tc_irq_out_o,
   output logic               error_irq_out_o
);

   // Register state.
   chan_vec_type          raw_tc;        // Terminal-count requests before masking.
   chan_vec_type          raw_error;     // Error requests before masking.
   chan_vec_type          masked_tc;     // Terminal-count requests after masking.
   chan_vec_type          masked_error;  // Error requests after masking.
   chan_vec_type          enabled_chan;  // Channels currently enabled.
   req_group_type         soft_req;      // Pending software requests.
   logic [CFG_WIDTH-1:0]  cfg;           // Enable and endianness bits.
   src_vec_type           sync_bypass;   // One bypasses a source's synchronizer.
   req_group_type         sync_stage1;   // First synchronizer stage.
   req_group_type         sync_stage2;   // Second synchronizer stage.
   req_group_type         periph_req;    // Peripheral requests after sync or bypass.
   logic                  write_fire;    // A write takes effect this edge.
   logic [31:0]           write_bits;    // Write data gated by byte enables.
   logic [31:0]           write_lanes;   // Byte lanes enabled for the current write.
   logic [31:0]           next_readdata; // Read value for the current address.

   // Expands byte enables into a bit mask.
   function automatic logic [31:0] lane_mask(input logic [3:0] be);
      logic [31:0] m;
      m = 32'h0000_0000;
      for (int b = 0; b < 4; b++)
      begin
         m[b*8 +: 8] = {8{be[b]}};
      end
      return m;
   endfunction : lane_mask

   // Next value of a write-one-to-set request bit; the set wins over completion.
   function automatic src_vec_type next_soft(input src_vec_type cur, input logic hit,
                                             input src_vec_type wbits, input src_vec_type done);
      return (cur & ~done) | (hit ? wbits : '0);
   endfunction : next_soft

   // Assertions all live in the single clock domain.
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   // A write is taken at the edge where waitrequest is seen low.
   assign write_fire = avs_write_i & ~avs_waitrequest_o;
   assign write_lanes = lane_mask(avs_byteenable_i);
   assign write_bits  = avs_writedata_i & write_lanes;

   // Masking happens here so that status reads and outputs agree.
   assign masked_tc    = raw_tc & tc_irq_mask_i;
   assign masked_error = raw_error & error_irq_mask_i;

   // Bus handshake: every access waits exactly one cycle, which keeps the
   // read mux off the critical path at the cost of one cycle of latency.
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         avs_waitrequest_o <= 1'b1;
      end
      else if ((avs_read_i | avs_write_i) & avs_waitrequest_o)
      begin
         // Answer in the following cycle.
         avs_waitrequest_o <= 1'b0;
      end
      else
      begin
         // Back to waiting once the answer has been taken.
         avs_waitrequest_o <= 1'b1;
      end
   end

   // Read mux; undefined upper bits and unmapped offsets read as zero.
   always_comb
   begin
      next_readdata = 32'h0000_0000;
      unique case (avs_address_i)
         OFS_MASKED_IRQ:     next_readdata[NUM_CHAN-1:0] = masked_tc | masked_error;
         OFS_MASKED_TC:      next_readdata[NUM_CHAN-1:0] = masked_tc;
         OFS_MASKED_ERROR:   next_readdata[NUM_CHAN-1:0] = masked_error;
         OFS_RAW_TC:         next_readdata[NUM_CHAN-1:0] = raw_tc;
         OFS_RAW_ERROR:      next_readdata[NUM_CHAN-1:0] = raw_error;
         OFS_ENABLED_CHAN:   next_readdata[NUM_CHAN-1:0] = enabled_chan;
         OFS_SW_BURST:       next_readdata[NUM_SRC-1:0]  = soft_req.burst;
         OFS_SW_SINGLE:      next_readdata[NUM_SRC-1:0]  = soft_req.single;
         OFS_SW_LAST_BURST:  next_readdata[NUM_SRC-1:0]  = soft_req.last_burst;
         OFS_SW_LAST_SINGLE: next_readdata[NUM_SRC-1:0]  = soft_req.last_single;
         OFS_CONFIG:         next_readdata[CFG_WIDTH-1:0] = cfg;
         OFS_SYNC_CONTROL:   next_readdata[NUM_SRC-1:0]  = sync_bypass;
         default:            next_readdata = 32'h0000_0000;
      endcase
   end

   // Read data is captured when the request is first seen and stands while waitrequest is low.
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         avs_readdata_o <= 32'h0000_0000;
      end
      else if (avs_read_i & avs_waitrequest_o)
      begin
         avs_readdata_o <= next_readdata;
      end
   end

   // Raw terminal-count flags; a new event in the clearing cycle survives.
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         raw_tc <= '0;
      end
      else if (write_fire && avs_address_i == OFS_TC_CLEAR)
      begin
         raw_tc <= (raw_tc & ~write_bits[NUM_CHAN-1:0]) | tc_event_i;
      end
      else
      begin
         raw_tc <= raw_tc | tc_event_i;
      end
   end

   // Raw error flags, cleared the same way.
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         raw_error <= '0;
      end
      else if (write_fire && avs_address_i == OFS_ERROR_CLEAR)
      begin
         raw_error <= (raw_error & ~write_bits[NUM_CHAN-1:0]) | error_event_i;
      end
      else
      begin
         raw_error <= raw_error | error_event_i;
      end
   end

   // Interrupt outputs, each the OR of its masked bits.
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         tc_irq_out_o       <= 1'b0;
         error_irq_out_o    <= 1'b0;
         combined_irq_out_o <= 1'b0;
      end
      else
      begin
         tc_irq_out_o       <= |masked_tc;
         error_irq_out_o    <= |masked_error;
         combined_irq_out_o <= |(masked_tc | masked_error);
      end
   end

   // Enabled channels: set by the channel's enable bit, cleared when the
   // channel is switched off or its final linked item has completed.
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         enabled_chan <= '0;
      end
      else
      begin
         enabled_chan <= (enabled_chan & ~(chan_disable_i | last_item_done_i)) | chan_enable_set_i;
      end
   end

   // Software request registers; zero bits written leave them alone.
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         soft_req <= '0;
      end
      else
      begin
         soft_req.burst <= next_soft(soft_req.burst, write_fire && avs_address_i == OFS_SW_BURST,
                                     write_bits[NUM_SRC-1:0], xfer_done_i);
         soft_req.single <= next_soft(soft_req.single, write_fire && avs_address_i == OFS_SW_SINGLE,
                                      write_bits[NUM_SRC-1:0], xfer_done_i);
         soft_req.last_burst <= next_soft(soft_req.last_burst, write_fire && avs_address_i == OFS_SW_LAST_BURST,
                                          write_bits[NUM_SRC-1:0], xfer_done_i);
         soft_req.last_single <= next_soft(soft_req.last_single,
                                           write_fire && avs_address_i == OFS_SW_LAST_SINGLE,
                                           write_bits[NUM_SRC-1:0], xfer_done_i);
      end
   end

   // Configuration and synchronizer control registers.
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         cfg         <= CFG_RESET;
         sync_bypass <= SYNC_RESET;
      end
      else if (write_fire && avs_address_i == OFS_CONFIG)
      begin
         cfg <= (cfg & ~write_lanes[CFG_WIDTH-1:0]) | write_bits[CFG_WIDTH-1:0];
      end
      else if (write_fire && avs_address_i == OFS_SYNC_CONTROL)
      begin
         sync_bypass <= (sync_bypass & ~write_lanes[NUM_SRC-1:0])
                        | write_bits[NUM_SRC-1:0];
      end
   end

   // Control outputs registered from the configuration flops, one cycle behind them.
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         controller_enable_o     <= 1'b0;
         master_one_big_endian_o <= 1'b0;
         master_two_big_endian_o <= 1'b0;
      end
      else
      begin
         controller_enable_o     <= cfg[CFG_ENABLE_BIT];
         master_one_big_endian_o <= cfg[CFG_M1_BIT];
         master_two_big_endian_o <= cfg[CFG_M2_BIT];
      end
   end

   // Two-stage synchronizers for all 64 request lines; the first stage feeds
   // only the second. While the controller is off they are held at zero, so
   // no stale level fires a request at re-enable and nothing toggles.
   for (genvar i = 0; i < REQ_BITS; i++)
   begin : g_sync
      always_ff @(posedge sys_clk_i)
      begin
         if (!rst_n_i || !cfg[CFG_ENABLE_BIT])
         begin
            sync_stage1[i] <= 1'b0;
            sync_stage2[i] <= 1'b0;
         end
         else
         begin
            sync_stage1[i] <= peripheral_request_in_i[i];
            sync_stage2[i] <= sync_stage1[i];
         end
      end
      // Bypassed sources react two cycles sooner but must share our clock.
      assign periph_req[i] = sync_bypass[i % NUM_SRC] ? peripheral_request_in_i[i] : sync_stage2[i];
   end

   // Requests handed to the transfer engine, peripheral or software.
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         engine_request_o <= '0;
      end
      else if (cfg[CFG_ENABLE_BIT])
      begin
         engine_request_o <= periph_req | soft_req;
      end
      else
      begin
         engine_request_o <= '0;
      end
   end

   // Responses to the peripherals; the peripheral must not raise a new
   // request while its clear response stands, so no guard is kept here.
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         request_clear_response_o  <= '0;
         terminal_count_response_o <= '0;
      end
      else
      begin
         request_clear_response_o  <= clear_resp_i;
         terminal_count_response_o <= tc_resp_i;
      end
   end

   // Checks on the logic above.
   property p_tc_clear;
      (write_fire && avs_address_i == OFS_TC_CLEAR && write_bits[0] && !tc_event_i[0]) |=> !raw_tc[0];
   endproperty
   a_tc_clear: assert property (p_tc_clear) else $error("Terminal-count clear missed.");

   property p_err_clear;
      (write_fire && avs_address_i == OFS_ERROR_CLEAR && write_bits[1] && !error_event_i[1]) |=> !raw_error[1];
   endproperty
   a_err_clear: assert property (p_err_clear) else $error("Error clear missed.");

   property p_tc_irq;
      (tc_event_i[2] && tc_irq_mask_i[2]) ##1 tc_irq_mask_i[2] |=> tc_irq_out_o;
   endproperty
   a_tc_irq: assert property (p_tc_irq) else $error("Terminal-count interrupt not raised.");

   property p_err_irq;
      (error_event_i[3] && error_irq_mask_i[3]) ##1 error_irq_mask_i[3] |=> error_irq_out_o && combined_irq_out_o;
   endproperty
   a_err_irq: assert property (p_err_irq) else $error("Error interrupt not raised.");

   property p_mask_irq;
      (raw_tc == '0 && error_irq_mask_i == '0) |=> !tc_irq_out_o && !error_irq_out_o && !combined_irq_out_o;
   endproperty
   a_mask_irq: assert property (p_mask_irq) else $error("Interrupt without masked cause.");

   property p_read_tc;
      (avs_read_i && !avs_waitrequest_o && avs_address_i == OFS_MASKED_TC) |-> avs_readdata_o[7:0] == $past(masked_tc);
   endproperty
   a_read_tc: assert property (p_read_tc) else $error("Masked status read wrong.");

   property p_soft_set;
      (write_fire && avs_address_i == OFS_SW_BURST && write_bits[3]) |=> soft_req.burst[3];
   endproperty
   a_soft_set: assert property (p_soft_set) else $error("Software burst request not set.");

   property p_soft_hold;
      (soft_req.single[3] && !xfer_done_i[3]) |=> soft_req.single[3];
   endproperty
   a_soft_hold: assert property (p_soft_hold) else $error("Software single request lost.");

   property p_disable;
      !cfg[CFG_ENABLE_BIT] |=> engine_request_o == '0 && !controller_enable_o;
   endproperty
   a_disable: assert property (p_disable) else $error("Requests pass while disabled.");

   property p_sync_path;
      (!sync_bypass[1] && cfg[CFG_ENABLE_BIT] && peripheral_request_in_i.single[1])[*3] |=> engine_request_o.single[1];
   endproperty
   a_sync_path: assert property (p_sync_path) else $error("Synchronized request not passed.");

   property p_chan_done;
      (last_item_done_i[3] && !chan_enable_set_i[3]) |=> !enabled_chan[3];
   endproperty
   a_chan_done: assert property (p_chan_done) else $error("Channel still enabled after last item.");

endmodule : dma_global_control_status

// ==== pkg/dma_global_pkg.sv ====
// Package with the register map, field positions and carrier types of the DMA global control block.
package dma_global_pkg;

   // Channel and request source counts.
   localparam int NUM_CHAN = 8;
   localparam int NUM_SRC  = 16;

   // Register byte offsets.
   localparam logic [7:0] OFS_MASKED_IRQ     = 8'h00;
   localparam logic [7:0] OFS_MASKED_TC      = 8'h04;
   localparam logic [7:0] OFS_TC_CLEAR       = 8'h08;
   localparam logic [7:0] OFS_MASKED_ERROR   = 8'h0C;
   localparam logic [7:0] OFS_ERROR_CLEAR    = 8'h10;
   localparam logic [7:0] OFS_RAW_TC         = 8'h14;
   localparam logic [7:0] OFS_RAW_ERROR      = 8'h18;
   localparam logic [7:0] OFS_ENABLED_CHAN   = 8'h1C;
   localparam logic [7:0] OFS_SW_BURST       = 8'h20;
   localparam logic [7:0] OFS_SW_SINGLE      = 8'h24;
   localparam logic [7:0] OFS_SW_LAST_BURST  = 8'h28;
   localparam logic [7:0] OFS_SW_LAST_SINGLE = 8'h2C;
   localparam logic [7:0] OFS_CONFIG         = 8'h30;
   localparam logic [7:0] OFS_SYNC_CONTROL   = 8'h34;

   // Configuration register fields and reset values.
   localparam int         CFG_ENABLE_BIT = 0;
   localparam int         CFG_M1_BIT     = 1;
   localparam int         CFG_M2_BIT     = 2;
   localparam int         CFG_WIDTH      = 3;
   localparam logic [2:0] CFG_RESET      = 3'h0;
   localparam logic [15:0] SYNC_RESET    = 16'h0000;

   // Per-channel and per-source bit vectors.
   typedef logic [NUM_CHAN-1:0] chan_vec_type;
   typedef logic [NUM_SRC-1:0]  src_vec_type;

   // The four request kinds of every source travel together.
   typedef struct packed {
      src_vec_type burst;
      src_vec_type single;
      src_vec_type last_burst;
      src_vec_type last_single;
   } req_group_type;

   localparam int REQ_BITS = 4 * NUM_SRC;

endpackage : dma_global_pkg

// ==== sim/periph_request_model.sv ====
// Peripheral model that raises DMA request handshakes on the controller clock.
`timescale 1ns/1ps
module periph_request_model
   import dma_global_pkg::*;
(
   input  wire logic          sys_clk_i,
   input  wire logic          rst_n_i,
   input  wire req_group_type want_i,
   input  wire src_vec_type   clear_seen_i,
   output req_group_type      request_o
);
   // Requests change just after an edge, like a same-clock peripheral.
   // A burst or single request may not newly rise while the clear response is high.
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         request_o <= '0;
      end
      else
      begin
         request_o.burst       <= want_i.burst & (request_o.burst | ~clear_seen_i);
         request_o.single      <= want_i.single & (request_o.single | ~clear_seen_i);
         request_o.last_burst  <= want_i.last_burst;
         request_o.last_single <= want_i.last_single;
      end
   end
endmodule : periph_request_model

// ==== sim/testbench.sv ====
// Self-checking testbench of the DMA global control and status block.
`timescale 1ns/1ps
module testbench;
   import dma_global_pkg::*;
   logic          sys_clk_i = 1'b0;
   logic          rst_n_i = 1'b0;
   logic [7:0]    avs_address_i = 8'h00;
   logic          avs_read_i = 1'b0;
   logic          avs_write_i = 1'b0;
   logic [31:0]   avs_writedata_i = 32'h0;
   logic [31:0]   avs_readdata_o;
   logic          avs_waitrequest_o;
   req_group_type want = '0;
   req_group_type periph_req;
   req_group_type engine_request_o;
   src_vec_type   xfer_done_i = '0, clear_resp_i = '0, tc_resp_i = '0;
   src_vec_type   request_clear_response_o, terminal_count_response_o;
   chan_vec_type  tc_event_i = '0, error_event_i = '0, tc_irq_mask_i = '0, error_irq_mask_i = '0;
   chan_vec_type  chan_enable_set_i = '0, last_item_done_i = '0, chan_disable_i = '0;
   logic          controller_enable_o, master_one_big_endian_o, master_two_big_endian_o;
   logic          combined_irq_out_o, tc_irq_out_o, error_irq_out_o;
   int            failures = 0, checks_done = 0, cycles = 0;
   logic [31:0]   rd;

   // Free-running 125 MHz clock.
   initial
   begin
      forever #4 sys_clk_i = ~sys_clk_i;
   end

   dma_global_control_status i_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
      .peripheral_request_in_i(periph_req), .xfer_done_i(xfer_done_i), .clear_resp_i(clear_resp_i),
      .tc_resp_i(tc_resp_i), .request_clear_response_o(request_clear_response_o),
      .terminal_count_response_o(terminal_count_response_o), .tc_event_i(tc_event_i),
      .error_event_i(error_event_i), .tc_irq_mask_i(tc_irq_mask_i), .error_irq_mask_i(error_irq_mask_i),
      .chan_enable_set_i(chan_enable_set_i), .chan_disable_i(chan_disable_i), .last_item_done_i(last_item_done_i),
      .engine_request_o(engine_request_o), .controller_enable_o(controller_enable_o),
      .master_one_big_endian_o(master_one_big_endian_o), .master_two_big_endian_o(master_two_big_endian_o),
      .combined_irq_out_o(combined_irq_out_o), .tc_irq_out_o(tc_irq_out_o), .error_irq_out_o(error_irq_out_o));

   periph_request_model i_periph (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .want_i(want),
      .clear_seen_i(request_clear_response_o), .request_o(periph_req));

   // Prints the counts and the verdict, then ends the run.
   task finish_test;
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : finish_test

   // Compares a seen value with its expectation; case inequality lets no unknown pass.
   task chk(input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         failures++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task ncyc(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask : ncyc

   // One Avalon-MM access; an edge passes first so the previous release is never overwritten.
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      avs_address_i   <= a;
      avs_write_i     <= wr;
      avs_read_i      <= !wr;
      avs_writedata_i <= d;
      // The request stands until waitrequest is seen low; only the bench timeout ends the wait.
      do
      begin
         @(posedge sys_clk_i);
      end
      while (avs_waitrequest_o !== 1'b0);
      rd = avs_readdata_o;
      avs_read_i  <= 1'b0;
      avs_write_i <= 1'b0;
   endtask : bus

   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task rdchk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk({32'h0, rd}, {32'h0, exp});
   endtask : rdchk

   // A hung bus or wait ends the run as a failure.
   always @(posedge sys_clk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         finish_test();
      end
   end

   initial
   begin
      ncyc(4);
      rst_n_i <= 1'b1;
      ncyc(1);
      rdchk(OFS_CONFIG, 32'h0);
      rdchk(OFS_SYNC_CONTROL, 32'h0);
      rdchk(8'h38, 32'h0);
      $display("reset test done");
      // Interrupts: channels 2 and 5 raise terminal count, 0 and 7 raise errors with errors masked off.
      tc_irq_mask_i    <= 8'hFF;
      tc_event_i       <= 8'h24;
      error_event_i    <= 8'h81;
      ncyc(1);
      tc_event_i    <= 8'h00;
      error_event_i <= 8'h00;
      ncyc(3);
      chk({tc_irq_out_o, error_irq_out_o, combined_irq_out_o}, 3'h5);
      rdchk(OFS_RAW_TC, 32'h24);
      rdchk(OFS_MASKED_TC, 32'h24);
      rdchk(OFS_RAW_ERROR, 32'h81);
      rdchk(OFS_MASKED_ERROR, 32'h0);
      error_irq_mask_i <= 8'h01;
      ncyc(3);
      chk(error_irq_out_o, 1'b1);
      rdchk(OFS_MASKED_IRQ, 32'h25);
      wr(OFS_RAW_TC, 32'hFFFF_FFFF);
      wr(OFS_TC_CLEAR, 32'h0000_0004);
      rdchk(OFS_RAW_TC, 32'h20);
      rdchk(OFS_TC_CLEAR, 32'h0);
      wr(OFS_ERROR_CLEAR, 32'h0000_0080);
      rdchk(OFS_MASKED_ERROR, 32'h01);
      wr(OFS_TC_CLEAR, 32'h0000_00FF);
      wr(OFS_ERROR_CLEAR, 32'h0000_00FF);
      ncyc(3);
      chk({tc_irq_out_o, error_irq_out_o, combined_irq_out_o}, 3'h0);
      // A lone error on channel 3 must reach the error and combined outputs only.
      error_irq_mask_i <= 8'h08;
      error_event_i    <= 8'h08;
      ncyc(1);
      error_event_i <= 8'h00;
      ncyc(3);
      chk({tc_irq_out_o, error_irq_out_o, combined_irq_out_o}, 3'h3);
      wr(OFS_ERROR_CLEAR, 32'h0000_0008);
      $display("interrupt test done");
      // Enabled channel view and its clearing by the last linked item.
      chan_enable_set_i <= 8'h0A;
      ncyc(1);
      chan_enable_set_i <= 8'h00;
      rdchk(OFS_ENABLED_CHAN, 32'h0A);
      last_item_done_i <= 8'h08;
      ncyc(1);
      last_item_done_i <= 8'h00;
      rdchk(OFS_ENABLED_CHAN, 32'h02);
      chan_disable_i <= 8'h02;
      ncyc(1);
      chan_disable_i <= 8'h00;
      rdchk(OFS_ENABLED_CHAN, 32'h00);
      $display("channel test done");
      // Configuration bits and the four software request registers.
      wr(OFS_CONFIG, 32'h7);
      ncyc(2);
      chk({master_two_big_endian_o, master_one_big_endian_o, controller_enable_o}, 3'h7);
      rdchk(OFS_CONFIG, 32'h7);
      for (int k = 0; k < 4; k++)
      begin
         wr(OFS_SW_BURST + 8'(4 * k), 32'h0008);
         wr(OFS_SW_BURST + 8'(4 * k), 32'h0000);
         rdchk(OFS_SW_BURST + 8'(4 * k), 32'h0008);
         chk(engine_request_o, 64'h8 << (16 * (3 - k)));
         xfer_done_i <= 16'h0008;
         ncyc(1);
         xfer_done_i <= 16'h0000;
         rdchk(OFS_SW_BURST + 8'(4 * k), 32'h0);
      end
      $display("software request test done");
      // Source 0 bypasses the synchronizer, source 1 goes through it.
      wr(OFS_SYNC_CONTROL, 32'h1);
      rdchk(OFS_SYNC_CONTROL, 32'h1);
      for (int k = 0; k < 4; k++)
      begin
         want <= 64'h3 << (16 * (3 - k));
         ncyc(4);
         chk(engine_request_o, 64'h1 << (16 * (3 - k)));
         ncyc(1);
         chk(engine_request_o, 64'h3 << (16 * (3 - k)));
         want <= '0;
         ncyc(5);
      end
      // Response copies, and a single request held back by the clear response.
      clear_resp_i <= 16'h0001;
      tc_resp_i    <= 16'h8000;
      ncyc(2);
      chk({request_clear_response_o, terminal_count_response_o}, 32'h0001_8000);
      want.single <= 16'h0001;
      ncyc(3);
      chk(engine_request_o, 64'h0);
      clear_resp_i <= 16'h0000;
      tc_resp_i    <= 16'h0000;
      ncyc(5);
      chk(engine_request_o.single, 16'h0001);
      wr(OFS_CONFIG, 32'h0);
      ncyc(2);
      chk(controller_enable_o, 1'b0);
      chk(engine_request_o, 64'h0);
      want <= '0;
      $display("peripheral request test done");
      finish_test();
   end
endmodule : testbench
